// ==== include/asrc_pkg.sv ====
// Constants for the sample readout controller.
// Assumes a 200 MHz system clock; all host pins are asynchronous to it.
package asrc_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned NUM_CH     = 8;
    localparam int unsigned HALF_CH    = 4;
    localparam int unsigned CH_W       = 3;
    localparam int unsigned BIT_W      = 6;
    localparam int unsigned CONV_NS    = 2000;
    localparam int unsigned CLK_NS     = 5;
    localparam int unsigned CONV_CYC   = CONV_NS / CLK_NS;
    localparam int unsigned CNT_W      = 12;
    localparam logic [2:0]  CH_LAST    = 3'h7;
    localparam logic [5:0]  SER_LAST   = 6'h3f;
    localparam logic [5:0]  SER_FLAG_N = 6'h0f;
    localparam logic [15:0] DATA_ZERO  = 16'h0000;
    typedef enum logic [1:0] {
        ASRC_IDLE = 2'b00,
        ASRC_WAIT = 2'b01,
        ASRC_CONV = 2'b10
    } asrc_state_t;
    typedef enum logic [1:0] {
        ASRC_WORD   = 2'b00,
        ASRC_SERIAL = 2'b01,
        ASRC_BYTE   = 2'b10
    } asrc_mode_t;
endpackage

// ==== design/asrc_ctrl.sv ====
// Conversion control and result readout for an eight-channel sampler.
// Assumes host pins are asynchronous; all are synchronised to clock.
// Serial clock must be slow against clock (bench: 64 ns period).
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl
    import asrc_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                reset_in,
    input  wire logic                sample_start_a,
    input  wire logic                sample_start_b,
    input  wire logic [2:0]          oversample_ratio_sel,
    input  wire logic                interface_select,
    input  wire logic                byte_serial_select,
    input  wire logic                byte_order_select,
    input  wire logic                chip_select_n,
    input  wire logic                read_strobe_n,
    input  wire logic [NUM_CH*DATA_W-1:0] sample_data,
    output logic                     busy,
    output logic                     hold_a,
    output logic                     hold_b,
    output logic                     first_channel_flag,
    output logic                     first_channel_flag_oe,
    output logic [DATA_W-1:0]        data_bus,
    output logic [DATA_W-1:0]        data_bus_oe,
    output logic                     serial_out_low_half,
    output logic                     serial_out_high_half,
    output logic                     serial_oe,
    output logic [2:0]               ratio
);
    ////////////////////////////////////////////////////////////////////
    // Synchronisers: reset, starts, select, strobe
    logic [1:0] s_rst, s_sa, s_sb, s_cs, s_rd;
    logic       rst_q, sa_q, sb_q, cs_q, rd_q;
    logic       mode_sel_q, byte_sel_q, order_q;
    logic [1:0] s_if, s_bs, s_ord;
    logic [2:0] s_os0, s_os1;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_rst <= 2'h0; s_sa <= 2'h0; s_sb <= 2'h0;
            s_cs  <= 2'h3; s_rd <= 2'h3;
            s_if  <= 2'h0; s_bs <= 2'h0; s_ord <= 2'h0;
            rst_q <= 1'b0; sa_q <= 1'b0; sb_q <= 1'b0;
            cs_q  <= 1'b1; rd_q <= 1'b1;
        end else begin
            s_rst <= {s_rst[0], reset_in};
            s_sa  <= {s_sa[0], sample_start_a};
            s_sb  <= {s_sb[0], sample_start_b};
            s_cs  <= {s_cs[0], chip_select_n};
            s_rd  <= {s_rd[0], read_strobe_n};
            s_if  <= {s_if[0], interface_select};
            s_bs  <= {s_bs[0], byte_serial_select};
            s_ord <= {s_ord[0], byte_order_select};
            rst_q <= s_rst[1];
            sa_q  <= s_sa[1];
            sb_q  <= s_sb[1];
            cs_q  <= s_cs[1];
            rd_q  <= s_rd[1];
        end
    end
    assign mode_sel_q = s_if[1];
    assign byte_sel_q = s_bs[1];
    assign order_q    = s_ord[1];

    logic soft_rst;
    logic sa_rise, sb_rise, cs_fall, cs_rise, rd_fall, rd_rise;
    assign soft_rst = s_rst[1];
    assign sa_rise  = s_sa[1] & ~sa_q;
    assign sb_rise  = s_sb[1] & ~sb_q;
    assign cs_fall  = ~s_cs[1] & cs_q;
    assign cs_rise  = s_cs[1] & ~cs_q;
    assign rd_fall  = ~s_rd[1] & rd_q;
    assign rd_rise  = s_rd[1] & ~rd_q;

    asrc_mode_t mode;
    always_comb begin
        if (!mode_sel_q) mode = ASRC_WORD;
        else if (byte_sel_q) mode = ASRC_BYTE;
        else mode = ASRC_SERIAL;
    end

    ////////////////////////////////////////////////////////////////////
    // Oversampling ratio is passed to the filter; host sets it once after reset
    // Ratio pins are asynchronous too, so they pass two flops first
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_os0 <= 3'h0;
            s_os1 <= 3'h0;
            ratio <= 3'h0;
        end else begin
            s_os0 <= oversample_ratio_sel;
            s_os1 <= s_os0;
            ratio <= s_os1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    asrc_state_t state;
    logic [CNT_W-1:0] conv_cnt;
    logic             results_valid;
    logic [NUM_CH*DATA_W-1:0] result;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ASRC_IDLE; hold_a <= 1'b0; hold_b <= 1'b0;
            busy <= 1'b0; conv_cnt <= '0; results_valid <= 1'b0;
            result <= '0;
        end else if (soft_rst) begin
            state <= ASRC_IDLE; hold_a <= 1'b0; hold_b <= 1'b0;
            busy <= 1'b0; conv_cnt <= '0; results_valid <= 1'b0;
            result <= '0;
        end else begin
            unique case (state)
                ASRC_IDLE, ASRC_WAIT: begin
                    if (sa_rise) hold_a <= 1'b1;
                    if (sb_rise) hold_b <= 1'b1;
                    if ((hold_a | sa_rise) & (hold_b | sb_rise)) begin
                        state    <= ASRC_CONV;
                        busy     <= 1'b1;
                        conv_cnt <= '0;
                    end else if (sa_rise | sb_rise) state <= ASRC_WAIT;
                end
                ASRC_CONV: begin
                    if (conv_cnt == CNT_W'(CONV_CYC - 1)) begin
                        result        <= sample_data;
                        results_valid <= 1'b1;
                        busy          <= 1'b0;
                        hold_a        <= 1'b0;
                        hold_b        <= 1'b0;
                        state         <= ASRC_IDLE;
                    end else conv_cnt <= conv_cnt + 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Readout pointer and output register
    function automatic logic [DATA_W-1:0] ch_word(input logic [CH_W-1:0] ch,
                                                  input logic [NUM_CH*DATA_W-1:0] r);
        ch_word = r[ch*DATA_W +: DATA_W];
    endfunction

    logic [CH_W-1:0]  rd_ch;
    logic             byte_half;
    logic [BIT_W-1:0] ser_cnt;
    logic [DATA_W-1:0] sh_lo, sh_hi;
    logic             sclk_fall;
    logic [DATA_W-1:0] cur_word, nxt_lo_word, nxt_hi_word;
    assign sclk_fall = rd_fall;
    // Words picked here: a function result cannot be part-selected
    assign cur_word    = ch_word(rd_ch, result);
    assign nxt_lo_word = ch_word({1'b0, 2'(ser_cnt[5:4] + 2'h1)}, result);
    assign nxt_hi_word = ch_word({1'b1, 2'(ser_cnt[5:4] + 2'h1)}, result);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_ch <= '0; byte_half <= 1'b0; ser_cnt <= '0;
            data_bus <= DATA_ZERO; first_channel_flag <= 1'b0;
            sh_lo <= DATA_ZERO; sh_hi <= DATA_ZERO;
            serial_out_low_half <= 1'b0; serial_out_high_half <= 1'b0;
        end else if (soft_rst) begin
            rd_ch <= '0; byte_half <= 1'b0; ser_cnt <= '0;
            data_bus <= DATA_ZERO; first_channel_flag <= 1'b0;
            sh_lo <= DATA_ZERO; sh_hi <= DATA_ZERO;
            serial_out_low_half <= 1'b0; serial_out_high_half <= 1'b0;
        end else if (cs_fall) begin
            rd_ch <= '0; byte_half <= 1'b0; ser_cnt <= '0;
            if (mode == ASRC_SERIAL) begin
                sh_lo <= ch_word(3'h0, result);
                sh_hi <= ch_word(3'h4, result);
                serial_out_low_half  <= result[DATA_W-1];
                serial_out_high_half <= result[HALF_CH*DATA_W+DATA_W-1];
                first_channel_flag   <= 1'b1;
            end else first_channel_flag <= 1'b0;
        end else if (!cs_q && rd_fall && mode == ASRC_WORD) begin
            data_bus           <= cur_word;
            first_channel_flag <= (rd_ch == '0);
            rd_ch              <= rd_ch + 1'b1;
        end else if (!cs_q && rd_fall && mode == ASRC_BYTE) begin
            data_bus[15:8] <= 8'h00;
            data_bus[7:0]  <= (order_q ^ byte_half) ?
                              cur_word[15:8] :
                              cur_word[7:0];
            first_channel_flag <= (rd_ch == '0);
            byte_half <= ~byte_half;
            if (byte_half) rd_ch <= rd_ch + 1'b1;
        end else if (!cs_q && mode == ASRC_SERIAL) begin
            if (sclk_fall && ser_cnt == SER_FLAG_N)
                first_channel_flag <= 1'b0;
            if (rd_rise) begin
                ser_cnt <= ser_cnt + 1'b1;
                if (ser_cnt[3:0] == 4'hf) begin
                    sh_lo <= nxt_lo_word;
                    sh_hi <= nxt_hi_word;
                    serial_out_low_half  <= nxt_lo_word[DATA_W-1];
                    serial_out_high_half <= nxt_hi_word[DATA_W-1];
                end else begin
                    serial_out_low_half  <= sh_lo[4'hf - ser_cnt[3:0] - 4'h1];
                    serial_out_high_half <= sh_hi[4'hf - ser_cnt[3:0] - 4'h1];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Drive enables; select rising floats everything
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_bus_oe <= DATA_ZERO; serial_oe <= 1'b0;
            first_channel_flag_oe <= 1'b0;
        end else if (cs_rise || s_cs[1]) begin
            data_bus_oe <= DATA_ZERO; serial_oe <= 1'b0;
            first_channel_flag_oe <= 1'b0;
        end else begin
            first_channel_flag_oe <= 1'b1;
            serial_oe   <= (mode == ASRC_SERIAL);
            if (!s_rd[1] && mode == ASRC_WORD) data_bus_oe <= 16'hffff;
            else if (!s_rd[1] && mode == ASRC_BYTE) data_bus_oe <= 16'h00ff;
            else data_bus_oe <= DATA_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_BUSY_AFTER_BOTH: assert property (@(posedge clock) disable iff (!nrst)
        $rose(busy) |-> $past(hold_a | sa_rise) && $past(hold_b | sb_rise))
        else $error("busy rose without both starts");
    AST_BUSY_LEN: assert property (@(posedge clock) disable iff (!nrst || soft_rst)
        $rose(busy) |-> busy [*8])
        else $error("busy fell too early");
    AST_RESET_CLEARS: assert property (@(posedge clock) disable iff (!nrst)
        soft_rst |=> data_bus == DATA_ZERO && !busy)
        else $error("reset did not clear outputs");
    AST_FLOAT_CS: assert property (@(posedge clock) disable iff (!nrst)
        s_cs[1] |=> data_bus_oe == DATA_ZERO && !serial_oe)
        else $error("outputs driven while deselected");
    AST_CONV_HOLDS: assert property (@(posedge clock) disable iff (!nrst)
        (state == ASRC_CONV && !soft_rst && conv_cnt != CNT_W'(CONV_CYC - 1)) |=> busy)
        else $error("busy dropped during conversion");
    AST_SER_FLAG: assert property (@(posedge clock) disable iff (!nrst)
        (cs_fall && !soft_rst && mode == ASRC_SERIAL) |=> first_channel_flag)
        else $error("serial first flag not raised");
    AST_BYTE_LANE: assert property (@(posedge clock) disable iff (!nrst)
        (mode == ASRC_BYTE) |=> data_bus_oe[15:8] == 8'h00)
        else $error("upper lines driven in byte mode");
endmodule
`default_nettype wire

// ==== tb/asrc_host_model.sv ====
// Host model: drives start pins, chip select and read strobe, captures results.
// Assumes the block sees pins about 3 clocks late; the serial clock idles high.
`timescale 1ns/1ps
`default_nettype none
module asrc_host_model (
    input  wire logic        clock,
    input  wire logic        busy,
    input  wire logic [15:0] data_bus,
    input  wire logic        first_channel_flag,
    input  wire logic        serial_out_low_half,
    input  wire logic        serial_out_high_half,
    output logic             sample_start_a,
    output logic             sample_start_b,
    output logic             chip_select_n,
    output logic             read_strobe_n,
    output logic [16:0]      got,
    output logic             got_stb,
    output logic             timed_out
);
    initial begin
        {sample_start_a, sample_start_b, chip_select_n, read_strobe_n} = 4'h3;
        {got, got_stb, timed_out} = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic post(input logic [16:0] v);
        got = v;
        got_stb = 1'b1;
        tick(1);
        got_stb = 1'b0;
        tick(1);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 600 && busy !== lvl; i++) tick(1);
        if (busy !== lvl) timed_out = 1'b1;
    endtask
    task automatic start(input bit split);
        sample_start_a = 1'b1;
        sample_start_b = !split;
        tick(8);
    endtask
    task automatic stop();
        sample_start_a = 1'b0;
        sample_start_b = 1'b0;
        tick(4);
    endtask
    // Starts are only lowered once busy has dropped
    task automatic finish();
        sample_start_b = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        stop();
    endtask
    task automatic strobe_read(input int n, input logic [15:0] mask);
        chip_select_n = 1'b0;
        tick(4);
        repeat (n) begin
            read_strobe_n = 1'b0;
            tick(8);
            post({first_channel_flag, data_bus & mask});
            read_strobe_n = 1'b1;
            tick(7);
        end
        chip_select_n = 1'b1;
        tick(6);
    endtask
    // Sample each bit just before the rising edge that replaces it
    task automatic serial_read(input int words);
        logic [15:0] lo;
        logic [15:0] hi;
        logic        f;
        chip_select_n = 1'b0;
        #64;
        repeat (words) begin
            for (int b = 0; b < 16; b++) begin
                read_strobe_n = 1'b0;
                #32;
                if (b == 0) f = first_channel_flag;
                lo = {lo[14:0], serial_out_low_half};
                hi = {hi[14:0], serial_out_high_half};
                read_strobe_n = 1'b1;
                #32;
            end
            post({f, lo});
            post({f, hi});
        end
        chip_select_n = 1'b1;
        tick(6);
    endtask
endmodule
`default_nettype wire

// ==== tb/asrc_ctrl_tb.sv ====
// Self-checking bench: host model reads results, a monitor compares them.
// Assumes asrc_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_tb;
    import asrc_pkg::*;
    logic                     clock, nrst, reset_in, iface, bsel, border, start_a, start_b;
    logic                     cs_n, rd_n, busy, hold_a, hold_b, flag, flag_oe, sol, soh;
    logic                     serial_oe, got_stb, timed_out;
    logic [2:0]               ratio_sel, ratio;
    logic [NUM_CH*DATA_W-1:0] sample_data;
    logic [DATA_W-1:0]        data_bus, data_bus_oe, w;
    logic [16:0]              got;
    logic [16:0]              expq[$];
    int                       fail_count = 0;
    int                       n_tests = 0;
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    asrc_ctrl dut (.clock(clock), .nrst(nrst), .reset_in(reset_in), .sample_start_a(start_a),
        .sample_start_b(start_b), .oversample_ratio_sel(ratio_sel), .interface_select(iface),
        .byte_serial_select(bsel), .byte_order_select(border), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .sample_data(sample_data), .busy(busy), .hold_a(hold_a),
        .hold_b(hold_b), .first_channel_flag(flag), .first_channel_flag_oe(flag_oe),
        .data_bus(data_bus), .data_bus_oe(data_bus_oe), .serial_out_low_half(sol),
        .serial_out_high_half(soh), .serial_oe(serial_oe), .ratio(ratio));
    asrc_host_model hm (.clock(clock), .busy(busy), .data_bus(data_bus),
        .first_channel_flag(flag), .serial_out_low_half(sol), .serial_out_high_half(soh),
        .sample_start_a(start_a), .sample_start_b(start_b), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .got(got), .got_stb(got_stb), .timed_out(timed_out));
    ////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ch(input int i);
        return sample_data[16*i +: 16];
    endfunction
    task automatic check_val(input logic [16:0] g, input logic [16:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic final_report();
        if (expq.size() != 0) fail_count++;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic set_mode(input logic i, input logic b, input logic o);
        iface = i;
        bsel = b;
        border = o;
        hm.tick(6);
    endtask
    // Fresh random samples every conversion except the one cut by reset, so stale data cannot match
    task automatic randomise();
        for (int i = 0; i < 4; i++) sample_data[32*i +: 32] = $urandom;
    endtask
    task automatic convert();
        randomise();
        hm.start(0);
        hm.finish();
    endtask
    always @(posedge clock) begin
        if (timed_out) begin
            $display("Error %0t: busy wait ran out", $time);
            fail_count++;
            final_report();
        end
        if (got_stb && expq.size() == 0) begin
            fail_count++;
            $display("Error %0t: result with nothing expected", $time);
        end else if (got_stb) check_val(got, expq.pop_front(), "read result");
    end
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, reset_in, iface, bsel, border} = '0;
        ratio_sel = 3'h0;
        sample_data = '0;
        void'($urandom(88790));
        repeat (4) @(posedge clock);
        #1 nrst = 1'b1;
        ratio_sel = 3'($urandom);
        hm.tick(8);
        check_val(17'(ratio), 17'(ratio_sel), "ratio");
        check_val(17'(data_bus_oe), 17'h0, "bus idle");
        randomise();
        hm.start(1);
        check_val(17'({hold_a, hold_b, busy}), 17'h4, "half hold");
        hm.finish();
        for (int i = 0; i < 8; i++) expq.push_back({i == 0, ch(i)});
        hm.strobe_read(8, 16'hffff);
        $display("test word read done");
        for (int o = 0; o < 2; o++) begin
            set_mode(1'b1, 1'b1, o[0]);
            convert();
            for (int i = 0; i < 16; i++) begin
                w = ch(i / 2);
                expq.push_back({i < 2, 8'h00, ((i % 2 == 0) == (o == 1)) ? w[15:8] : w[7:0]});
            end
            hm.strobe_read(16, 16'h00ff);
        end
        $display("test byte read done");
        set_mode(1'b1, 1'b0, 1'b0);
        convert();
        for (int k = 0; k < 2; k++) begin
            expq.push_back({k == 0, ch(k)});
            expq.push_back({k == 0, ch(k + 4)});
        end
        hm.serial_read(2);
        $display("test serial read done");
        set_mode(1'b0, 1'b0, 1'b0);
        hm.start(0);
        reset_in = 1'b1;
        hm.tick(6);
        check_val(17'(busy), 17'h0, "busy after reset");
        hm.stop();
        reset_in = 1'b0;
        hm.tick(10);
        for (int i = 0; i < 8; i++) expq.push_back({i == 0, 16'h0000});
        hm.strobe_read(8, 16'hffff);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
